// ==== src/distributed_dma.sv ====
// Socket DMA slave control: status, software request, mode, master clear
// and mask registers, a transfer sequencer and a 16-word data FIFO.
// Assumes all inputs are synchronous to i_core_clk and that the host bus
// cycle generator consumes the FIFO output and the current address.
`include "dma_slave_defs.svh"

module xfer_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // Clock and reset.
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_clear,
  // Filling side.
  input  wire logic [WIDTH-1:0]           i_in_data,
  input  wire logic                       i_in_valid,
  output logic                            o_in_ready,
  // Draining side.
  output logic [WIDTH-1:0]                o_out_data,
  output logic                            o_out_valid,
  input  wire logic                       i_out_ready,
  // Fill level.
  output logic [$clog2(DEPTH):0]          o_level
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_type;

  fifo_state_type           st_r;
  fifo_state_type           st_nxt;
  logic [WIDTH-1:0]         mem_r [DEPTH];
  logic                     push;
  logic                     pop;
  logic                     full;
  logic                     empty;

  assign full        = (st_r.wr[AW] != st_r.rd[AW]) &&
                       (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]);
  assign empty       = (st_r.wr == st_r.rd);
  assign push        = i_in_valid && !full;
  assign pop         = i_out_ready && !empty;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_r[st_r.rd[AW-1:0]];
  assign o_level     = st_r.wr - st_r.rd;

  always_comb
  begin
    st_nxt = st_r;
    if (i_clear)
    begin
      st_nxt = '0;
    end
    else
    begin
      if (push)
      begin
        st_nxt.wr = st_r.wr + 1'b1;
      end
      if (pop)
      begin
        st_nxt.rd = st_r.rd + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push && !i_clear)
    begin
      mem_r[st_r.wr[AW-1:0]] <= i_in_data;
    end
  end

endmodule : xfer_fifo

// Overview of operation
// - Status bits 7-4 all read one while card request held, zero after.
// - Request status bits follow the card request regardless of mask.
// - Terminal count sets all four status bits 3-0.
// - Terminal count bits clear on status read or channel reset.
// - Any write to the software request register raises a software request.
// - Mode bits 7-6 select demand, single or block; 11 reserved.
// - Address increments after each transfer if bit 5 zero, else decrements.
// - Mode bit 4 enables auto-initialisation; zero after reset.
// - Mode bits 3-2 select none, write (card to memory) or read.
// - Mode bits 1-0 are read-only and read zero.
// - Any master clear write returns every register to reset state, except status and mask bits set by a same-cycle event.
// - Only bit 0 of the mask register has meaning, the channel mask.
// - Mask bit sets automatically when the card is removed.
// - Mask one ignores card requests; mask zero services them.
module distributed_dma
  import dma_slave_pkg::*;
(
  // Clock and reset.
  input  wire logic                      i_core_clk,
  input  wire logic                      i_sys_rst,
  // Register port.
  input  wire logic [`REG_ADDR_W-1:0]    i_reg_addr,
  input  wire logic [`REG_DATA_W-1:0]    i_reg_wdata,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  output logic      [`REG_DATA_W-1:0]    o_reg_rdata,
  // Card side.
  input  wire logic                      i_card_dreq,
  input  wire logic                      i_card_present,
  // Base values from the address and count registers.
  input  wire logic [`CNT_W-1:0]         i_base_addr,
  input  wire logic [`CNT_W-1:0]         i_base_count,
  input  wire logic                      i_base_load,
  // Data source.
  input  wire logic [`FIFO_W-1:0]        i_src_data,
  input  wire logic                      i_src_valid,
  output logic                           o_src_ready,
  // Data sink.
  output logic      [`FIFO_W-1:0]        o_dst_data,
  output logic                           o_dst_valid,
  input  wire logic                      i_dst_ready,
  // Channel status.
  output logic      [`CNT_W-1:0]         o_cur_addr,
  output logic      [`CNT_W-1:0]         o_cur_count,
  output logic                           o_tc,
  output logic                           o_busy,
  output logic                           o_dir_read
);

  localparam ctrl_state_type RESET_STATE = '{
    state:                ST_IDLE,
    transfer_mode_select: `MODE_DEMAND,
    address_direction:    1'b0,
    auto_reload_enable:   1'b0,
    transfer_type_select: `TYPE_NONE,
    channel_mask_bit:     `MASK_RESET,
    request_status_bits:  1'b0,
    terminal_count_bits:  `TC_NONE,
    sw_request:           1'b0,
    present_seen:         1'b0,
    cur_addr:             `CNT_ZERO,
    cur_count:            `CNT_ZERO,
    src_ready:            1'b0,
    tc_pulse:             1'b0,
    busy:                 1'b0,
    dir_read:             1'b0,
    rdata:                `RDATA_ZERO
  };

  ctrl_state_type           st_r;
  ctrl_state_type           st_nxt;
  logic [`LEVEL_W-1:0]      fifo_level;
  logic                     fifo_in_ready;
  logic                     xfer;
  logic                     tc_evt;
  logic                     card_req;
  logic                     type_ok;
  logic                     removal;
  logic                     wr_mode;
  logic                     wr_sw_req;
  logic                     wr_mclr;
  logic                     wr_mask;
  logic                     rd_status;

  assign xfer      = i_src_valid && st_r.src_ready;
  assign tc_evt    = xfer && (st_r.cur_count == `CNT_ZERO);
  assign card_req  = i_card_dreq && !st_r.channel_mask_bit;
  assign type_ok   = (st_r.transfer_type_select == `TYPE_WRITE) ||
                     (st_r.transfer_type_select == `TYPE_READ);
  assign removal   = st_r.present_seen && !i_card_present;
  assign wr_mode   = i_reg_wr && (i_reg_addr == `OFF_MODE);
  assign wr_sw_req = i_reg_wr && (i_reg_addr == `OFF_SW_REQUEST);
  assign wr_mclr   = i_reg_wr && (i_reg_addr == `OFF_MASTER_CLR);
  assign wr_mask   = i_reg_wr && (i_reg_addr == `OFF_MASK);
  assign rd_status = i_reg_rd && (i_reg_addr == `OFF_STATUS);

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rdata    = `RDATA_ZERO;

    // Transfer sequencer.
    unique case (st_r.state)
      ST_IDLE:
      begin
        if (type_ok)
        begin
          if (st_r.transfer_mode_select == `MODE_BLOCK)
          begin
            if (card_req || st_r.sw_request)
            begin
              st_nxt.state      = ST_ACTIVE;
              st_nxt.sw_request = 1'b0;
            end
          end
          else if (st_r.transfer_mode_select != `MODE_RESV && card_req)
          begin
            st_nxt.state = ST_ACTIVE;
          end
        end
      end
      ST_ACTIVE:
      begin
        // A single-mode word waits for the request to drop even at terminal
        // count, so a request that is still held never gets a second word.
        if (!type_ok)
        begin
          st_nxt.state = ST_IDLE;
        end
        else if (st_r.transfer_mode_select == `MODE_SINGLE && xfer)
        begin
          st_nxt.state = ST_HOLD;
        end
        else if (tc_evt)
        begin
          st_nxt.state = ST_IDLE;
        end
        else if (st_r.transfer_mode_select == `MODE_DEMAND && !card_req)
        begin
          st_nxt.state = ST_IDLE;
        end
      end
      ST_HOLD:
      begin
        if (!card_req)
        begin
          st_nxt.state = ST_IDLE;
        end
      end
      default:
      begin
        st_nxt.state = ST_IDLE;
      end
    endcase

    // Address and count stepping, with reload at terminal count.
    if (i_base_load || (tc_evt && st_r.auto_reload_enable))
    begin
      st_nxt.cur_addr  = i_base_addr;
      st_nxt.cur_count = i_base_count;
    end
    else if (xfer)
    begin
      st_nxt.cur_addr  = st_r.address_direction ?
                         st_r.cur_addr - `CNT_ONE :
                         st_r.cur_addr + `CNT_ONE;
      st_nxt.cur_count = st_r.cur_count - `CNT_ONE;
    end

    // Register writes.
    if (wr_mode)
    begin
      st_nxt.transfer_mode_select =
        i_reg_wdata[`MODE_SEL_HI:`MODE_SEL_LO];
      st_nxt.address_direction    = i_reg_wdata[`DIR_BIT];
      st_nxt.auto_reload_enable   = i_reg_wdata[`AUTO_BIT];
      st_nxt.transfer_type_select =
        i_reg_wdata[`TYPE_SEL_HI:`TYPE_SEL_LO];
    end
    if (wr_sw_req)
    begin
      st_nxt.sw_request = 1'b1;
    end
    if (wr_mask)
    begin
      st_nxt.channel_mask_bit = i_reg_wdata[0];
    end

    // Register reads answer in the following cycle.
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        `OFF_STATUS:
          st_nxt.rdata = {{4{st_r.request_status_bits}},
                          st_r.terminal_count_bits};
        `OFF_MODE:
          st_nxt.rdata = {st_r.transfer_mode_select,
                          st_r.address_direction,
                          st_r.auto_reload_enable,
                          st_r.transfer_type_select,
                          `RESV_ZERO2};
        `OFF_MASK:
          st_nxt.rdata = {`RESV_ZERO7, st_r.channel_mask_bit};
        default:
          st_nxt.rdata = `RDATA_ZERO;
      endcase
    end
    if (rd_status)
    begin
      st_nxt.terminal_count_bits = `TC_NONE;
    end

    // Master clear puts every register back to its reset state.
    if (wr_mclr)
    begin
      st_nxt          = RESET_STATE;
      st_nxt.rdata    = `RDATA_ZERO;
    end

    // Hardware events set after any clear, so a set is never lost.
    st_nxt.request_status_bits = i_card_dreq;
    st_nxt.present_seen        = i_card_present;
    st_nxt.tc_pulse            = tc_evt;
    if (tc_evt)
    begin
      st_nxt.terminal_count_bits = `TC_ALL;
    end
    if (removal)
    begin
      st_nxt.channel_mask_bit = 1'b1;
    end

    // Source ready leaves room for one word accepted on a stale ready.
    st_nxt.src_ready = (st_nxt.state == ST_ACTIVE) && !wr_mclr &&
                       fifo_in_ready &&
                       (({1'b0, fifo_level} + {5'h00, xfer}) <
                        6'(`FIFO_DEPTH));
    st_nxt.busy      = (st_nxt.state != ST_IDLE);
    st_nxt.dir_read  = (st_nxt.transfer_type_select == `TYPE_READ);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      st_r <= RESET_STATE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  xfer_fifo
  #(
    .WIDTH (`FIFO_W),
    .DEPTH (`FIFO_DEPTH)
  )
  u_fifo
  (
    .i_clk       (i_core_clk),
    .i_rst       (i_sys_rst),
    .i_clear     (wr_mclr),
    .i_in_data   (i_src_data),
    .i_in_valid  (xfer),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (o_dst_data),
    .o_out_valid (o_dst_valid),
    .i_out_ready (i_dst_ready),
    .o_level     (fifo_level)
  );

  assign o_reg_rdata = st_r.rdata;
  assign o_src_ready = st_r.src_ready;
  assign o_cur_addr  = st_r.cur_addr;
  assign o_cur_count = st_r.cur_count;
  assign o_tc        = st_r.tc_pulse;
  assign o_busy      = st_r.busy;
  assign o_dir_read  = st_r.dir_read;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_single_xfer;
    xfer && st_r.state == ST_ACTIVE &&
    st_r.transfer_mode_select == `MODE_SINGLE && !wr_mclr;
  endsequence

  sequence s_stay_quiet;
    !o_src_ready [*2];
  endsequence

  a_req_follow: assert property (##1 st_r.request_status_bits ==
    $past(i_card_dreq)) else $error("request status lags the card line");
  a_status_read: assert property (rd_status |=>
    o_reg_rdata[7:4] == {4{$past(i_card_dreq, 2)}})
    else $error("status upper nibble wrong");
  a_tc_set: assert property (tc_evt |=>
    st_r.terminal_count_bits == `TC_ALL && o_tc)
    else $error("terminal count not flagged");
  a_tc_clear: assert property (rd_status && !tc_evt |=>
    st_r.terminal_count_bits == `TC_NONE)
    else $error("terminal count not cleared by read");
  a_sw_request: assert property (wr_sw_req && !wr_mclr |=>
    st_r.sw_request || st_r.state == ST_ACTIVE)
    else $error("software request lost");
  a_mode_read: assert property (i_reg_rd &&
    i_reg_addr == `OFF_MODE |=> o_reg_rdata[1:0] == `RESV_ZERO2 &&
    o_reg_rdata[7:6] == $past(st_r.transfer_mode_select))
    else $error("mode readback wrong");
  a_master_clear: assert property (wr_mclr |=>
    st_r.state == ST_IDLE && st_r.transfer_mode_select == `MODE_DEMAND &&
    st_r.transfer_type_select == `TYPE_NONE && !st_r.sw_request &&
    st_r.cur_count == `CNT_ZERO && !o_src_ready)
    else $error("master clear incomplete");
  a_mask_removal: assert property (removal |=>
    st_r.channel_mask_bit) else $error("mask not set on removal");
  a_masked_idle: assert property (st_r.state == ST_IDLE &&
    st_r.channel_mask_bit && !st_r.sw_request |=> st_r.state == ST_IDLE)
    else $error("masked request serviced");
  a_addr_step: assert property (xfer && !tc_evt && !i_base_load
    && !wr_mclr |=> o_cur_addr == ($past(st_r.address_direction) ?
    $past(o_cur_addr) - `CNT_ONE : $past(o_cur_addr) + `CNT_ONE))
    else $error("address step wrong");
  a_auto_reload: assert property (tc_evt && st_r.auto_reload_enable
    && !wr_mclr |=> o_cur_count == $past(i_base_count))
    else $error("auto reload missed");
  a_single_one: assert property (s_single_xfer |=>
    s_stay_quiet) else $error("single mode moved a second word");

endmodule : distributed_dma

// ==== src/dma_slave_defs.svh ====
// Named constants for the socket DMA slave control block.
// Assumes an 8-bit register port with a 4-bit byte offset.
`ifndef DMA_SLAVE_DEFS_SVH
`define DMA_SLAVE_DEFS_SVH

`define REG_ADDR_W      4
`define REG_DATA_W      8
`define OFF_STATUS      4'h8
`define OFF_SW_REQUEST  4'h9
`define OFF_MODE        4'hb
`define OFF_MASTER_CLR  4'hd
`define OFF_MASK        4'hf

`define MODE_SEL_HI     7
`define MODE_SEL_LO     6
`define DIR_BIT         5
`define AUTO_BIT        4
`define TYPE_SEL_HI     3
`define TYPE_SEL_LO     2

`define MODE_DEMAND     2'h0
`define MODE_SINGLE     2'h1
`define MODE_BLOCK      2'h2
`define MODE_RESV       2'h3
`define TYPE_NONE       2'h0
`define TYPE_WRITE      2'h1
`define TYPE_READ       2'h2

`define RESV_ZERO2      2'h0
`define RESV_ZERO7      7'h00
`define TC_ALL          4'hf
`define TC_NONE         4'h0
`define RDATA_ZERO      8'h00
`define MASK_RESET      1'b0

`define CNT_W           16
`define CNT_ZERO        16'h0000
`define CNT_ONE         16'h0001
`define FIFO_W          8
`define FIFO_DEPTH      16
`define LEVEL_W         5

`endif

// ==== src/dma_slave_pkg.sv ====
// Types shared by the socket DMA slave control block.
// Assumes the constants header is on the include path.
`include "dma_slave_defs.svh"

package dma_slave_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_HOLD   = 3'b100
  } chan_state_type;

  typedef struct packed
  {
    chan_state_type           state;
    logic [1:0]               transfer_mode_select;
    logic                     address_direction;
    logic                     auto_reload_enable;
    logic [1:0]               transfer_type_select;
    logic                     channel_mask_bit;
    logic                     request_status_bits;
    logic [3:0]               terminal_count_bits;
    logic                     sw_request;
    logic                     present_seen;
    logic [`CNT_W-1:0]        cur_addr;
    logic [`CNT_W-1:0]        cur_count;
    logic                     src_ready;
    logic                     tc_pulse;
    logic                     busy;
    logic                     dir_read;
    logic [`REG_DATA_W-1:0]   rdata;
  } ctrl_state_type;

endpackage : dma_slave_pkg

// ==== test/card_model.sv ====
// Behavioural card and data-path partner for the socket DMA slave block.
// Assumes the bench steers request, presence and sink stall per scenario.
module card_model
(
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Steering from the bench.
  input  wire logic       i_dreq_on,
  input  wire logic       i_present_on,
  input  wire logic       i_stall,
  // Data source towards the block.
  output logic [7:0]      o_src_data = 8'h00,
  output logic            o_src_valid,
  input  wire logic       i_src_ready,
  // Data sink and card pins.
  output logic            o_dst_ready = 1'b1,
  output logic            o_card_dreq = 1'b0,
  output logic            o_card_present = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;

  // The source always has a word; each accepted word is the next count.
  assign o_src_valid = 1'b1;

  always_ff @(posedge i_clk)
  begin
    o_card_dreq    <= i_dreq_on;
    o_card_present <= i_present_on;
    o_dst_ready    <= !i_stall;
    if (i_rst)
      o_src_data <= 8'h00;
    else if (o_src_valid && i_src_ready)
      o_src_data <= o_src_data + 8'h01;
  end
endmodule : card_model

// ==== test/testbench.sv ====
// Self-checking bench for the socket DMA slave control block.
// Assumes the constants header is on the include path.
`include "dma_slave_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata;
  logic        wr = 1'b0, rd = 1'b0;
  logic        dreq_on = 1'b0, present_on = 1'b1, stall = 1'b0;
  logic [15:0] base_addr = 16'h0000, base_count = 16'h0000;
  logic        base_load = 1'b0;
  logic [7:0]  src_data, dst_data;
  logic        src_valid, src_ready, dst_valid, dst_ready;
  logic        card_dreq, card_present, tc, busy, dir_read;
  logic [15:0] cur_addr, cur_count;
  int          n_mismatch = 0, checks_done = 0;
  int          n_taken = 0, n_popped = 0, n_tc = 0, s, t;

  distributed_dma u_dut (.i_core_clk(clk), .i_sys_rst(rst),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_card_dreq(card_dreq),
    .i_card_present(card_present), .i_base_addr(base_addr),
    .i_base_count(base_count), .i_base_load(base_load),
    .i_src_data(src_data), .i_src_valid(src_valid), .o_src_ready(src_ready),
    .o_dst_data(dst_data), .o_dst_valid(dst_valid), .i_dst_ready(dst_ready),
    .o_cur_addr(cur_addr), .o_cur_count(cur_count), .o_tc(tc),
    .o_busy(busy), .o_dir_read(dir_read));

  card_model u_card (.i_clk(clk), .i_rst(rst), .i_dreq_on(dreq_on),
    .i_present_on(present_on), .i_stall(stall), .o_src_data(src_data),
    .o_src_valid(src_valid), .i_src_ready(src_ready),
    .o_dst_ready(dst_ready), .o_card_dreq(card_dreq),
    .o_card_present(card_present));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Words handed over, words popped and end-of-count pulses.
  always @(posedge clk)
  begin
    if (!rst && src_valid === 1'b1 && src_ready === 1'b1)
      n_taken++;
    if (!rst && dst_valid === 1'b1 && dst_ready === 1'b1)
    begin
      check("fifo order", {8'h00, dst_data},
            {8'h00, n_popped[7:0]});
      n_popped++;
    end
    if (!rst && tc === 1'b1)
      n_tc++;
  end

  task automatic cycles(int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  task automatic reg_wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(string name, logic [3:0] a, logic [7:0] exp);
    logic [7:0] d;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    check(name, {8'h00, d}, {8'h00, exp});
  endtask : reg_chk

  task automatic timed_out;
    n_mismatch++;
    $display("Error wait expected done seen timeout");
    report_and_stop();
  endtask : timed_out

  task automatic wait_taken(int n);
    int i;
    for (i = 0; i < 300 && n_taken < n; i++)
      @(posedge clk);
    if (n_taken < n)
      timed_out();
  endtask : wait_taken

  task automatic wait_idle;
    int i;
    for (i = 0; i < 300 && !(busy === 1'b0 && dst_valid === 1'b0); i++)
      @(posedge clk);
    if (!(busy === 1'b0 && dst_valid === 1'b0))
      timed_out();
  endtask : wait_idle

  task automatic load_base(logic [15:0] a, logic [15:0] c);
    @(posedge clk);
    base_addr <= a;
    base_count <= c;
    base_load <= 1'b1;
    @(posedge clk);
    base_load <= 1'b0;
  endtask : load_base

  task automatic set_dreq(logic v);
    @(posedge clk);
    dreq_on <= v;
  endtask : set_dreq

  task automatic t_reset_values;
    reg_chk("mode", `OFF_MODE, 8'h00);
    reg_chk("mask", `OFF_MASK, 8'h00);
    reg_chk("status", `OFF_STATUS, 8'h00);
    reg_chk("sw request", `OFF_SW_REQUEST, 8'h00);
    reg_chk("unmapped", 4'h3, 8'h00);
  endtask : t_reset_values

  task automatic t_field_access;
    reg_wr(`OFF_MODE, 8'hff);
    reg_chk("mode", `OFF_MODE, 8'hfc);
    reg_wr(`OFF_MODE, 8'h90);
    reg_chk("mode", `OFF_MODE, 8'h90);
    reg_wr(`OFF_MASK, 8'hff);
    reg_chk("mask", `OFF_MASK, 8'h01);
    reg_wr(`OFF_MODE, 8'h00);
  endtask : t_field_access

  task automatic t_request_status;
    set_dreq(1'b1);
    cycles(4);
    reg_chk("status", `OFF_STATUS, 8'hf0);
    set_dreq(1'b0);
    cycles(4);
    reg_chk("status", `OFF_STATUS, 8'h00);
    reg_wr(`OFF_MASK, 8'h00);
  endtask : t_request_status

  task automatic t_single_tc;
    load_base(16'h0010, 16'h0001);
    reg_wr(`OFF_MODE, 8'h44);
    s = n_taken;
    t = n_tc;
    set_dreq(1'b1);
    wait_taken(s + 1);
    cycles(10);
    check("single words", 16'(n_taken - s), 16'h0001);
    check("hold busy", {15'h0000, busy}, 16'h0001);
    set_dreq(1'b0);
    wait_idle();
    set_dreq(1'b1);
    wait_taken(s + 2);
    set_dreq(1'b0);
    wait_idle();
    check("tc pulses", 16'(n_tc - t), 16'h0001);
    check("address up", cur_addr, 16'h0012);
    check("count", cur_count, 16'hffff);
    reg_chk("status", `OFF_STATUS, 8'h0f);
    reg_chk("status", `OFF_STATUS, 8'h00);
  endtask : t_single_tc

  task automatic t_demand_down;
    load_base(16'h0100, 16'h00ff);
    reg_wr(`OFF_MODE, 8'h28);
    s = n_taken;
    set_dreq(1'b1);
    wait_taken(s + 3);
    set_dreq(1'b0);
    wait_idle();
    check("dir read", {15'h0000, dir_read}, 16'h0001);
    check("address down", cur_addr, 16'h0100 - 16'(n_taken - s));
    check("count", cur_count, 16'h00ff - 16'(n_taken - s));
  endtask : t_demand_down

  task automatic t_block_fill;
    reg_wr(`OFF_MASK, 8'h01);
    load_base(16'h0000, 16'h0013);
    reg_wr(`OFF_MODE, 8'h94);
    stall <= 1'b1;
    s = n_taken;
    t = n_tc;
    reg_wr(`OFF_SW_REQUEST, 8'h5a);
    wait_taken(s + 16);
    cycles(20);
    check("fifo full words", 16'(n_taken - s), 16'h0010);
    check("src ready", {15'h0000, src_ready}, 16'h0000);
    stall <= 1'b0;
    wait_taken(s + 20);
    wait_idle();
    check("block words", 16'(n_taken - s), 16'h0014);
    check("tc pulses", 16'(n_tc - t), 16'h0001);
    check("reload count", cur_count, 16'h0013);
    check("reload address", cur_addr, 16'h0000);
    reg_chk("status", `OFF_STATUS, 8'h0f);
  endtask : t_block_fill

  task automatic t_masked;
    reg_wr(`OFF_MODE, 8'h04);
    s = n_taken;
    set_dreq(1'b1);
    cycles(12);
    check("masked busy", {15'h0000, busy}, 16'h0000);
    check("masked words", 16'(n_taken - s), 16'h0000);
    reg_chk("status", `OFF_STATUS, 8'hf0);
    reg_wr(`OFF_MASK, 8'h00);
    wait_taken(s + 1);
    set_dreq(1'b0);
    wait_idle();
  endtask : t_masked

  task automatic t_removal_clear;
    @(posedge clk);
    present_on <= 1'b0;
    cycles(4);
    reg_chk("mask", `OFF_MASK, 8'h01);
    @(posedge clk);
    present_on <= 1'b1;
    cycles(4);
    reg_wr(`OFF_MASTER_CLR, 8'h00);
    cycles(1);
    reg_chk("mode", `OFF_MODE, 8'h00);
    reg_chk("mask", `OFF_MASK, 8'h00);
    check("address", cur_addr, 16'h0000);
  endtask : t_removal_clear

  initial
  begin
    cycles(16);
    rst <= 1'b0;
    t_reset_values();
    t_field_access();
    t_request_status();
    t_single_tc();
    t_demand_down();
    t_block_fill();
    t_masked();
    t_removal_clear();
    report_and_stop();
  end
endmodule : testbench
